// [logic/ctsx_exec.v]
/*
  execution unit for nibble swap, table read/write, test-and-skip,
  xor literal and subtract with borrow. one step per instruction cycle:
  each mclk_i edge stands for a completed q1..q4 cycle. file data is read
  combinationally through fdata_i for the address on faddr_o; program
  memory answers pm_word_i in the same cycle as pm_rd_o.
*/
`timescale 1ns/1ps
`include "ctsx_defines.vh"

module ctsx_exec
#(
  parameter PTR_W  = 21,
  parameter HOLD_N = 8
)
(
  // clock and reset
  input  wire             mclk_i,
  input  wire             rst_i,
  // decoded instruction
  input  wire [15:0]      instr_i,
  input  wire             instr_valid_i,
  // bank select and file data
  input  wire [3:0]       bank_select_pointer_i,
  input  wire [7:0]       fdata_i,
  output wire [11:0]      faddr_o,
  output reg              fwe_o,
  output reg  [7:0]       fwdata_o,
  // program memory
  output wire [PTR_W-2:0] pm_word_addr_o,
  output reg              pm_rd_o,
  input  wire [15:0]      pm_word_i,
  // core state
  output reg  [7:0]       w_o,
  output reg  [4:0]       status_o,
  output reg  [PTR_W-1:0] table_pointer_o,
  output reg  [7:0]       table_latch_o,
  output wire [8*HOLD_N-1:0] holding_o,
  // pipeline control
  output wire             stall_o,
  output reg              flush_o
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire is_swap = instr_valid_i & (instr_i[15:10] == `CTSX_OPC_SWAP_HI);
  wire is_subb = instr_valid_i & (instr_i[15:10] == `CTSX_OPC_SUBB_HI);
  wire is_test = instr_valid_i & (instr_i[15:9] == `CTSX_OPC_TEST_HI);
  wire is_xorl = instr_valid_i & (instr_i[15:8] == `CTSX_OPC_XORL_HI);
  // table ops share one prefix; bit 2 then tells a read from a write
  wire is_tbl  = instr_valid_i & (instr_i[15:3] == `CTSX_OPC_TBL_HI);
  wire is_trd  = is_tbl & (instr_i[3:2] == `CTSX_OPC_TABLE_READ_OP_LO);
  wire is_twt  = is_tbl & (instr_i[3:2] == `CTSX_OPC_TABLE_WRITE_OP_LO);
  // destination and access bits sit in the same place for swap and subtract; test has the access bit only
  wire dest_f  = instr_i[`CTSX_DEST_BIT];

  // fixed bank: low half maps to bank 0, high half to the top bank
  // the bank pointer is ignored there, so core registers stay reachable from any bank
  assign faddr_o = (instr_i[`CTSX_ACC_BIT] == `CTSX_ACC_FIXED) ?
                   {{4{instr_i[7]}}, instr_i[7:0]} :
                   {bank_select_pointer_i, instr_i[7:0]};

  // ------------------------------------------------------------
  // alu
  // ------------------------------------------------------------
  wire [7:0] alu_res;
  wire [4:0] alu_flags;
  wire [4:0] alu_we;
  // op 0 (swap) doubles as the idle value; its flag mask is empty
  wire [1:0] alu_op = is_xorl ? 2'h1 : (is_subb ? 2'h2 : 2'h0);

  ctsx_alu u_alu
  (
    .f_val_i   (fdata_i),
    .w_val_i   (w_o),
    .lit_i     (instr_i[7:0]),
    .carry_i   (status_o[`CTSX_FLAG_C]),
    .op_i      (alu_op),
    .res_o     (alu_res),
    .flags_o   (alu_flags),
    .flag_we_o (alu_we)
  );

  // ------------------------------------------------------------
  // table op sequencing
  // ------------------------------------------------------------
  // two-state sequencer: decode cycle, then the memory cycle
  // a table op seen in the memory cycle is ignored, so the fetch stage must not issue one there
  localparam ST_IDLE = 1'b0;
  localparam ST_MEM  = 1'b1;

  reg             state_reg;
  reg             is_wt_reg;
  // the access address is frozen at the decode edge, so the pointer step
  // cannot move the byte that the memory cycle reads or writes
  reg [PTR_W-1:0] addr_reg;
  // holding bytes reset to the erased level of the flash
  reg [7:0]       hold_reg [0:HOLD_N-1];

  // the first cycle is a pure decode cycle; the fetch stage holds off
  assign stall_o = (state_reg == ST_IDLE) & is_tbl;

  wire [1:0]       mode    = instr_i[1:0];
  wire [PTR_W-1:0] ptr_inc = table_pointer_o + {{(PTR_W-1){1'b0}}, 1'b1};
  wire [PTR_W-1:0] ptr_dec = table_pointer_o - {{(PTR_W-1){1'b0}}, 1'b1};
  // pre-increment uses the new pointer for the access
  wire [PTR_W-1:0] acc_addr = (mode == `CTSX_MODE_PREINC) ? ptr_inc : table_pointer_o;

  // only the low pointer bit steers the byte lane; the rest is the word address
  assign pm_word_addr_o = addr_reg[PTR_W-1:1];
  wire [7:0] pm_byte = addr_reg[0] ? pm_word_i[15:8] : pm_word_i[7:0];

  // flatten the holding array onto one bus for the programming logic
  genvar gi;
  generate
    for (gi = 0; gi < HOLD_N; gi = gi + 1)
    begin : g_hold
      assign holding_o[8*gi+7:8*gi] = hold_reg[gi];
    end
  endgenerate

  integer k;
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg       <= ST_IDLE;
      is_wt_reg       <= 1'b0;
      addr_reg        <= `CTSX_PTR_RST;
      table_pointer_o <= `CTSX_PTR_RST;
      table_latch_o   <= `CTSX_LATCH_RST;
      pm_rd_o         <= 1'b0;
      for (k = 0; k < HOLD_N; k = k + 1)
        hold_reg[k] <= 8'hff;
    end
    else
    begin
      pm_rd_o <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (is_trd | is_twt)
          begin
            state_reg <= ST_MEM;
            is_wt_reg <= is_twt;
            addr_reg  <= acc_addr;
            pm_rd_o   <= is_trd;
            // the pointer moves at the decode edge; pre-increment has already used it
            case (mode)
              `CTSX_MODE_KEEP:    table_pointer_o <= table_pointer_o;
              `CTSX_MODE_POSTDEC: table_pointer_o <= ptr_dec;
              default:            table_pointer_o <= ptr_inc;
            endcase
          end
        end
        ST_MEM:
        begin
          state_reg <= ST_IDLE;
          // memory cycle: exactly one of the two transfers happens here
          if (is_wt_reg)
            hold_reg[addr_reg[2:0]] <= table_latch_o;
          else
            table_latch_o <= pm_byte;
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // byte ops: w, status, file write, skip
  // ------------------------------------------------------------
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      w_o      <= `CTSX_W_RST;
      status_o <= `CTSX_STATUS_RST;
      fwe_o    <= 1'b0;
      fwdata_o <= 8'h00;
      flush_o  <= 1'b0;
    end
    else
    begin
      fwe_o   <= 1'b0;
      // zero operand turns the next fetched word into a no-operation
      flush_o <= is_test & (fdata_i == 8'h00);
      if (is_swap | is_subb)
      begin
        if (dest_f == `CTSX_DEST_F)
        begin
          fwe_o    <= 1'b1;
          fwdata_o <= alu_res;
        end
        else
          w_o <= alu_res;
      end
      if (is_xorl)
        w_o <= alu_res;
      // flag writes are masked per bit, so swap and skip leave status alone
      status_o <= (status_o & ~alu_we) | (alu_flags & alu_we);
    end
  end

endmodule

// [logic/ctsx_defines.vh]
/*
  opcode fields, destination/access codes, flag positions and timing counts
  for the table, swap, skip and xor execution unit. assumes plain verilog
  and inclusion once per compile unit under its bare name.
*/
`ifndef CTSX_DEFINES_VH
`define CTSX_DEFINES_VH

// ------------------------------------------------------------
// opcode patterns
// ------------------------------------------------------------
`define CTSX_OPC_SWAP_HI   6'h0e
`define CTSX_OPC_SUBB_HI   6'h16
`define CTSX_OPC_TEST_HI   7'h33
`define CTSX_OPC_XORL_HI   8'h0a
`define CTSX_OPC_TBL_HI    13'h0001
`define CTSX_OPC_TABLE_READ_OP_LO  2'h2
`define CTSX_OPC_TABLE_WRITE_OP_LO  2'h3

// ------------------------------------------------------------
// field positions and codes
// ------------------------------------------------------------
`define CTSX_DEST_BIT      9
`define CTSX_ACC_BIT       8
`define CTSX_DEST_W        1'b0
`define CTSX_DEST_F        1'b1
`define CTSX_ACC_FIXED     1'b0
`define CTSX_ACC_BANKED    1'b1
`define CTSX_MODE_KEEP     2'h0
`define CTSX_MODE_POSTINC  2'h1
`define CTSX_MODE_POSTDEC  2'h2
`define CTSX_MODE_PREINC   2'h3

// ------------------------------------------------------------
// status flag positions (n, ov, z, dc, c)
// ------------------------------------------------------------
`define CTSX_FLAG_C   0
`define CTSX_FLAG_DC  1
`define CTSX_FLAG_Z   2
`define CTSX_FLAG_OV  3
`define CTSX_FLAG_N   4

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define CTSX_PTR_RST     21'h000000
`define CTSX_LATCH_RST   8'h00
`define CTSX_W_RST       8'h00
`define CTSX_STATUS_RST  5'h00
`define CTSX_TBL_CYCLES  2

`endif

// [logic/ctsx_alu.v]
/*
  combinational byte alu for swap, xor and subtract-with-borrow.
  assumes operands are stable for the whole execute cycle.
*/
`timescale 1ns/1ps
module ctsx_alu
(
  // operands
  input  wire [7:0] f_val_i,
  input  wire [7:0] w_val_i,
  input  wire [7:0] lit_i,
  input  wire       carry_i,
  // operation select: 0 swap, 1 xor literal, 2 subtract borrow
  input  wire [1:0] op_i,
  // result
  output reg  [7:0] res_o,
  output reg  [4:0] flags_o,
  output reg  [4:0] flag_we_o
);
`include "ctsx_defines.vh"

  reg [8:0] diff;
  reg [4:0] ldiff;

  always @*
  begin
    diff      = {1'b0, f_val_i} - {1'b0, w_val_i} - {8'h00, ~carry_i};
    ldiff     = {1'b0, f_val_i[3:0]} - {1'b0, w_val_i[3:0]} - {4'h0, ~carry_i};
    res_o     = 8'h00;
    flags_o   = 5'h00;
    flag_we_o = 5'h00;
    case (op_i)
      2'h0:
      begin
        res_o = {f_val_i[3:0], f_val_i[7:4]};
      end
      2'h1:
      begin
        res_o = w_val_i ^ lit_i;
        flags_o[`CTSX_FLAG_N] = res_o[7];
        flags_o[`CTSX_FLAG_Z] = (res_o == 8'h00);
        flag_we_o = (5'h01 << `CTSX_FLAG_N) | (5'h01 << `CTSX_FLAG_Z);
      end
      2'h2:
      begin
        // borrow is carry inverted, so carry set means no borrow
        res_o = diff[7:0];
        flags_o[`CTSX_FLAG_C]  = ~diff[8];
        flags_o[`CTSX_FLAG_DC] = ~ldiff[4];
        flags_o[`CTSX_FLAG_Z]  = (diff[7:0] == 8'h00);
        flags_o[`CTSX_FLAG_N]  = diff[7];
        flags_o[`CTSX_FLAG_OV] = (f_val_i[7] ^ w_val_i[7]) & (f_val_i[7] ^ diff[7]);
        flag_we_o = 5'h1f;
      end
      default:
      begin
        res_o = 8'h00;
      end
    endcase
  end

endmodule

// [verif/ctsx_monitor.sv]
/* port checker for ctsx_exec, bound to every instance.
   assumes each mclk_i edge ends one instruction cycle. */
`timescale 1ns/1ps
module ctsx_monitor
#(
  parameter PTR_W  = 21,
  parameter HOLD_N = 8
)
(
  // watched ports
  input wire                mclk_i,
  input wire                rst_i,
  input wire [15:0]         instr_i,
  input wire                instr_valid_i,
  input wire [3:0]          bank_select_pointer_i,
  input wire [7:0]          fdata_i,
  input wire [11:0]         faddr_o,
  input wire                fwe_o,
  input wire [7:0]          fwdata_o,
  input wire [PTR_W-2:0]    pm_word_addr_o,
  input wire                pm_rd_o,
  input wire [15:0]         pm_word_i,
  input wire [7:0]          w_o,
  input wire [4:0]          status_o,
  input wire [PTR_W-1:0]    table_pointer_o,
  input wire [7:0]          table_latch_o,
  input wire [8*HOLD_N-1:0] holding_o,
  input wire                stall_o,
  input wire                flush_o
);
  // --------------------------------
  // decode
  // --------------------------------
  wire             sw  = instr_valid_i & (instr_i[15:10] == 6'h0e);
  wire             ts  = instr_valid_i & (instr_i[15:9] == 7'h33);
  wire             xl  = instr_valid_i & (instr_i[15:8] == 8'h0a);
  wire             sb  = instr_valid_i & (instr_i[15:10] == 6'h16);
  wire [7:0]       f   = instr_i[7:0];
  wire [7:0]       sf  = {fdata_i[3:0], fdata_i[7:4]};
  wire [PTR_W-1:0] stp = (instr_i[1:0] == 2'h0) ? {PTR_W{1'b0}} :
                         (instr_i[1:0] == 2'h2) ? {PTR_W{1'b1}} : {{(PTR_W-1){1'b0}}, 1'b1};
  // byte address used by the access, pre-increment applied
  reg  [PTR_W-1:0] acc_reg;
  always @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      acc_reg <= {PTR_W{1'b0}};
    else if (stall_o)
      acc_reg <= table_pointer_o + {{(PTR_W-1){1'b0}}, instr_i[1:0] == 2'h3};
  default clocking mon_cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_bank_addr: assert property ((sw | ts | sb) |->
    faddr_o == (instr_i[8] ? {bank_select_pointer_i, f} : {{4{f[7]}}, f})) else $error("bad file address");
  a_swap_wreg: assert property (sw && !instr_i[9] |=> w_o == $past(sf) && !fwe_o)
    else $error("bad swap result");
  a_flags_kept: assert property (sw | ts |=> $stable(status_o))
    else $error("flags changed");
  a_skip_flush: assert property (ts |=> flush_o == ($past(fdata_i) == 8'h00))
    else $error("bad skip");
  a_xor_wreg: assert property (xl |=> w_o == $past(w_o ^ f) && status_o[4] == w_o[7] &&
    status_o[2] == (w_o == 8'h00) && status_o[1:0] == $past(status_o[1:0])) else $error("bad xor");
  a_subb_wreg: assert property (sb && !instr_i[9] |=>
    w_o == $past(fdata_i - w_o - {7'h00, ~status_o[0]})) else $error("bad subtract");
  a_tbl_two: assert property (stall_o |=> !stall_o && pm_rd_o == ($past(instr_i[3:2]) == 2'h2))
    else $error("bad table timing");
  a_ptr_step: assert property (stall_o |=> table_pointer_o == $past(table_pointer_o) + $past(stp))
    else $error("bad pointer step");
  a_read_byte: assert property (pm_rd_o |-> pm_word_addr_o == acc_reg[PTR_W-1:1] ##1
    table_latch_o == (acc_reg[0] ? $past(pm_word_i[15:8]) : $past(pm_word_i[7:0]))) else $error("bad read");
  a_hold_byte: assert property (stall_o && instr_i[3:2] == 2'h3 |=> ##1
    holding_o[acc_reg[2:0]*8 +: 8] == table_latch_o) else $error("bad holding byte");
  c_flush: cover property (ts ##1 flush_o);
  c_read: cover property (pm_rd_o);
  c_fwrite: cover property (fwe_o);
endmodule
bind ctsx_exec ctsx_monitor #(.PTR_W(PTR_W), .HOLD_N(HOLD_N)) u_mon
(
  .mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .bank_select_pointer_i(bank_select_pointer_i), .fdata_i(fdata_i), .faddr_o(faddr_o),
  .fwe_o(fwe_o), .fwdata_o(fwdata_o), .pm_word_addr_o(pm_word_addr_o), .pm_rd_o(pm_rd_o),
  .pm_word_i(pm_word_i), .w_o(w_o), .status_o(status_o), .table_pointer_o(table_pointer_o),
  .table_latch_o(table_latch_o), .holding_o(holding_o), .stall_o(stall_o), .flush_o(flush_o)
);

// [verif/ctsx_pmem_model.sv]
/* program memory seen by the table read path.
   assumes the word is sampled only while pm_rd_i is high. */
`timescale 1ns/1ps
module ctsx_pmem_model
(
  // clock
  input  wire        mclk_i,
  // word request
  input  wire [19:0] pm_word_addr_i,
  input  wire        pm_rd_i,
  // word answer
  output reg  [15:0] pm_word_o
);
  reg [15:0] last_reg = 16'h0000;
  // outside a read the bus shows the inverse, so a stale sample never matches
  always @*
    if (pm_rd_i)
      pm_word_o = {pm_word_addr_i[7:0] ^ 8'ha5, pm_word_addr_i[7:0] ^ 8'h3c};
    else
      pm_word_o = ~last_reg;
  always @(posedge mclk_i)
    if (pm_rd_i)
      last_reg <= pm_word_o;
endmodule

// [verif/tb_top.sv]
/* self-checking bench for ctsx_exec with a program memory model.
   assumes the bound monitor and one edge per instruction cycle. */
`timescale 1ns/1ps
module tb_top;
  reg         mclk_i;
  reg         rst_i;
  reg  [15:0] instr_i;
  reg         instr_valid_i;
  reg  [3:0]  bank_select_pointer_i;
  reg  [7:0]  fdata_i;
  wire [11:0] faddr_o;
  wire        fwe_o;
  wire [7:0]  fwdata_o;
  wire [19:0] pm_word_addr_o;
  wire        pm_rd_o;
  wire [15:0] pm_word_i;
  wire [7:0]  w_o;
  wire [4:0]  status_o;
  wire [20:0] table_pointer_o;
  wire [7:0]  table_latch_o;
  wire [63:0] holding_o;
  wire        stall_o;
  wire        flush_o;
  integer     err_count;
  integer     checks;
  integer     k;
  reg  [20:0] p;
  reg  [7:0]  lat;
  reg  [63:0] hx;
  ctsx_exec uut
  (
    .mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .bank_select_pointer_i(bank_select_pointer_i), .fdata_i(fdata_i), .faddr_o(faddr_o),
    .fwe_o(fwe_o), .fwdata_o(fwdata_o), .pm_word_addr_o(pm_word_addr_o), .pm_rd_o(pm_rd_o),
    .pm_word_i(pm_word_i), .w_o(w_o), .status_o(status_o), .table_pointer_o(table_pointer_o),
    .table_latch_o(table_latch_o), .holding_o(holding_o), .stall_o(stall_o), .flush_o(flush_o)
  );
  ctsx_pmem_model u_pm (.mclk_i(mclk_i), .pm_word_addr_i(pm_word_addr_o), .pm_rd_i(pm_rd_o), .pm_word_o(pm_word_i));
  // --------------------------------
  // helpers
  // --------------------------------
  task chk(input [127:0] got, input [127:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // fa of 12'hfff skips the file address compare for non-file ops
  task ex(input [15:0] i, input s, input [11:0] fa);
    begin
      instr_i = i;
      instr_valid_i = 1'b1;
      #1 chk(stall_o, s);
      if (fa !== 12'hfff)
        chk(faddr_o, fa);
      @(posedge mclk_i);
      #1;
    end
  endtask
  task results;
    begin
      if (err_count == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task t_reset;
    chk({w_o, status_o, table_latch_o, table_pointer_o, fwe_o, flush_o, pm_rd_o, holding_o}, {45'h0, hx});
  endtask
  task t_swap;
    begin
      fdata_i = 8'h53;
      bank_select_pointer_i = 4'h3;
      ex(16'h3945, 1'b0, 12'h345);
      chk({fwe_o, w_o}, {1'b0, 8'h35});
      fdata_i = 8'ha7;
      ex(16'h3a90, 1'b0, 12'hf90);
      chk({fwe_o, fwdata_o, w_o, status_o}, {1'b1, 8'h7a, 8'h35, 5'h00});
    end
  endtask
  task t_xor;
    begin
      ex(16'h0aaf, 1'b0, 12'hfff);
      chk({w_o, status_o}, {8'h9a, 5'h10});
      ex(16'h0a9a, 1'b0, 12'hfff);
      chk({w_o, status_o}, {8'h00, 5'h04});
    end
  endtask
  task t_skip;
    begin
      fdata_i = 8'h00;
      ex(16'h6610, 1'b0, 12'h010);
      chk(flush_o, 1'b1);
      instr_valid_i = 1'b0;
      @(posedge mclk_i);
      #1 fdata_i = 8'h05;
      chk(flush_o, 1'b0);
      ex(16'h6722, 1'b0, 12'h322);
      chk({flush_o, status_o}, {1'b0, 5'h04});
    end
  endtask
  task t_subb;
    begin
      ex(16'h0a1a, 1'b0, 12'hfff);
      fdata_i = 8'h1b;
      ex(16'h5820, 1'b0, 12'h020);
      chk({w_o, status_o}, {8'h00, 5'h07});
      ex(16'h0a0e, 1'b0, 12'hfff);
      fdata_i = 8'h03;
      ex(16'h5a20, 1'b0, 12'h020);
      chk({fwe_o, fwdata_o, w_o, status_o}, {1'b1, 8'hf5, 8'h0e, 5'h10});
    end
  endtask
  task t_tbl(input [1:0] m, input wr);
    reg [20:0] a;
    begin
      a = p + {20'h0, m == 2'h3};
      ex({12'h000, 1'b1, wr, m}, 1'b1, 12'hfff);
      p = (m == 2'h0) ? p : (m == 2'h2) ? p - 21'h1 : p + 21'h1;
      chk({table_pointer_o, pm_rd_o, stall_o}, {p, !wr, 1'b0});
      if (!wr)
        chk(pm_word_addr_o, a[20:1]);
      instr_valid_i = 1'b0;
      @(posedge mclk_i);
      #1;
      if (wr)
        hx[a[2:0]*8 +: 8] = lat;
      else
        lat = a[0] ? a[8:1] ^ 8'ha5 : a[8:1] ^ 8'h3c;
      chk({table_latch_o, holding_o, pm_rd_o}, {lat, hx, 1'b0});
    end
  endtask
  task t_tbls;
    begin
      for (k = 0; k < 8; k = k + 1)
        t_tbl(k[1:0], k[2]);
      for (k = 0; k < 3; k = k + 1)
        t_tbl(2'h2, 1'b1);
      t_tbl(2'h1, 1'b0);
      t_tbl(2'h3, 1'b1);
    end
  endtask
  // --------------------------------
  // run
  // --------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial
  begin
    #100000;
    err_count = err_count + 1;
    results;
  end
  initial
  begin
    rst_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    bank_select_pointer_i = 4'h0;
    fdata_i = 8'h00;
    err_count = 0;
    checks = 0;
    p = 21'h0;
    lat = 8'h00;
    hx = {8{8'hff}};
    repeat (6) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    t_reset;
    t_swap;
    t_xor;
    t_skip;
    t_subb;
    t_tbls;
    results;
  end
endmodule
